// [src/cmsc_top.sv]
// clock configuration and per-module stop control, wishbone slave
// assumes a classic wishbone master on i_ref_clk and gate cells
// downstream that pass a module clock while its run bit is high
//
// Notes on behaviour
// - a clock select field of 000 in bits 2..0 gives an undivided clock.
// - a pll field of 00 in bits 1..0 gives a one to one pll factor.
// - stop bit 15 enables all-module-clock-stop mode when one.
// - stop bit 14 halts the external bus dma when one, runs it at zero.
// - stop bit 13 halts the on-chip dma when one, runs it at zero.
// - stop bit 12 halts the transfer controller when one.
// - stop bit 11 halts the pulse timer unit and bit 0 the byte timer.
// - stop bit 10 halts the pulse pattern generator when one.
// - stop bits 9, 8, 7 halt converter pairs 0-1, 2-3, 4-5 when one.
// - stop bit 6 halts the analog to digital converter when one.
// - stop bits 5 down to 1 halt serial channels 4 down to 0 when one.
// - extended bits 4 and 3 halt two-wire interfaces 1 and 0 when one.
`include "cmsc_cfg.svh"
module cmsc_top #(
    parameter logic [2:0] RST_DIV = `CMSC_DIV_ONE,
    parameter logic [1:0] RST_PLL = `CMSC_PLL_ONE
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [25:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic i_sleep_req,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output cmsc_pkg::cmsc_clk_cfg_t o_clk_cfg,
    output logic [7:0] o_sysctl,
    output logic [`CMSC_NUM_PERIPH-1:0] o_periph_run,
    output logic o_all_halt
);

    cmsc_pkg::cmsc_state_t state_reg;
    cmsc_pkg::cmsc_state_t state_next;
    logic [`CMSC_IDX_W-1:0] idx;
    logic req;
    logic wr_commit;

    // word index of the access; low two address bits are ignored
    assign idx = i_wb_adr[25:2];
    assign req = i_wb_cyc & i_wb_stb;
    // writes land on the edge where the master sees ack
    assign wr_commit = req & i_wb_we & state_reg.ack;

    // address match, used by read mux, write path and checks
    function automatic logic hit(
        input logic [`CMSC_IDX_W-1:0] a,
        input logic [`CMSC_IDX_W-1:0] b
    );
        hit = (a == b);
    endfunction : hit

    // byte lane merge for a 16-bit register in the low lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction : merge16

    // read mux; unmapped words and reserved bits read zero
    function automatic logic [31:0] read_word(
        input cmsc_pkg::cmsc_state_t s,
        input logic [`CMSC_IDX_W-1:0] a
    );
        read_word = 32'h0000_0000;
        if (hit(a, `CMSC_IDX_SCLK)) begin
            read_word[2:0] = s.clk.sys_div_sel;
        end else if (hit(a, `CMSC_IDX_PLL)) begin
            read_word[1:0] = s.clk.pll_mult;
        end else if (hit(a, `CMSC_IDX_SYSCTL)) begin
            read_word[7:0] = s.sysctl;
        end else if (hit(a, `CMSC_IDX_STOP)) begin
            read_word[15:0] = s.stop;
        end else if (hit(a, `CMSC_IDX_EXSTOP)) begin
            read_word[`CMSC_BIT_TW1:`CMSC_BIT_TW0] = s.exstop;
        end
    endfunction : read_word

    // next state: bus handshake, register writes, clock gating
    always_comb begin
        logic [15:0] m;
        logic halt;
        m = 16'h0000;
        halt = 1'b0;
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.bus = cmsc_pkg::CMSC_BUS_IDLE;
        case (state_reg.bus)
            cmsc_pkg::CMSC_BUS_IDLE: begin
                // answer one cycle after the request is seen
                if (req) begin
                    state_next.bus = cmsc_pkg::CMSC_BUS_ACK;
                    state_next.ack = 1'b1;
                    state_next.rdat = read_word(state_reg, idx);
                end
            end
            cmsc_pkg::CMSC_BUS_ACK: begin
                // ack drops here, so back to back needs a gap cycle
                if (wr_commit) begin
                    if (hit(idx, `CMSC_IDX_SCLK) && i_wb_sel[0]) begin
                        state_next.clk.sys_div_sel = i_wb_dat[2:0];
                    end
                    if (hit(idx, `CMSC_IDX_PLL) && i_wb_sel[0]) begin
                        state_next.clk.pll_mult = i_wb_dat[1:0];
                    end
                    if (hit(idx, `CMSC_IDX_SYSCTL) && i_wb_sel[0]) begin
                        state_next.sysctl = i_wb_dat[7:0];
                    end
                    if (hit(idx, `CMSC_IDX_STOP)) begin
                        state_next.stop = merge16(state_reg.stop,
                            i_wb_dat, i_wb_sel);
                    end
                    if (hit(idx, `CMSC_IDX_EXSTOP)) begin
                        m = merge16({11'h000, state_reg.exstop, 3'h0},
                            i_wb_dat, i_wb_sel);
                        state_next.exstop = m[`CMSC_BIT_TW1:`CMSC_BIT_TW0];
                    end
                end
            end
            default: begin
                state_next.bus = cmsc_pkg::CMSC_BUS_IDLE;
            end
        endcase
        // all-module halt only bites while the core asks to sleep
        halt = state_next.stop[`CMSC_BIT_ALL_MODULE_CLOCK_HALT_EN] & i_sleep_req;
        state_next.all_halt = halt;
        // gate enables track the new stop bits, so a module resumes
        // on the very cycle after its bit clears; its own registers
        // are untouched since only its clock is withheld
        for (int i = 0; i < `CMSC_MAIN_PERIPH; i++) begin
            state_next.run[i] = ~state_next.stop[i] & ~halt;
        end
        state_next.run[`CMSC_MAIN_PERIPH] =
            ~state_next.exstop[0] & ~halt;
        state_next.run[`CMSC_MAIN_PERIPH+1] =
            ~state_next.exstop[1] & ~halt;
    end

    // single register stage for all state
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg.bus <= cmsc_pkg::CMSC_BUS_IDLE;
            state_reg.ack <= 1'b0;
            state_reg.rdat <= 32'h0000_0000;
            state_reg.clk.sys_div_sel <= RST_DIV;
            state_reg.clk.pll_mult <= RST_PLL;
            state_reg.sysctl <= `CMSC_RST_SYSCTL;
            state_reg.stop <= `CMSC_RST_STOP;
            state_reg.exstop <= `CMSC_RST_EXSTOP;
            state_reg.run <= '1;
            state_reg.all_halt <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output straight from the state register
    assign o_wb_ack = state_reg.ack;
    assign o_wb_dat = state_reg.rdat;
    assign o_clk_cfg = state_reg.clk;
    assign o_sysctl = state_reg.sysctl;
    assign o_periph_run = state_reg.run;
    assign o_all_halt = state_reg.all_halt;

    // checks on the bus, the clock fields and the gate enables
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_wr_sclk_one;
        wr_commit && hit(idx, `CMSC_IDX_SCLK) && i_wb_sel[0]
            && i_wb_dat[2:0] == `CMSC_DIV_ONE;
    endsequence

    sequence s_wr_pll_one;
        wr_commit && hit(idx, `CMSC_IDX_PLL) && i_wb_sel[0]
            && i_wb_dat[1:0] == `CMSC_PLL_ONE;
    endsequence

    sequence s_new_req;
        req && !o_wb_ack && state_reg.bus == cmsc_pkg::CMSC_BUS_IDLE;
    endsequence

    sequence s_halt_mode;
        state_reg.stop[`CMSC_BIT_ALL_MODULE_CLOCK_HALT_EN] && i_sleep_req
            && !(wr_commit && hit(idx, `CMSC_IDX_STOP));
    endsequence

    chk_ack_timing: assert property (
        s_new_req |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not given for exactly one cycle");

    chk_div_undivided: assert property (
        s_wr_sclk_one |=> o_clk_cfg.sys_div_sel == `CMSC_DIV_ONE
            ##1 $stable(o_clk_cfg.sys_div_sel) || wr_commit)
        else $error("clock select not undivided after write");

    chk_pll_unity: assert property (
        s_wr_pll_one |=> o_clk_cfg.pll_mult == `CMSC_PLL_ONE)
        else $error("pll factor not one after write");

    chk_all_halt_on: assert property (
        s_halt_mode |=> o_all_halt && o_periph_run == '0)
        else $error("all-module halt did not stop every clock");

    chk_all_halt_off: assert property (
        !state_reg.stop[`CMSC_BIT_ALL_MODULE_CLOCK_HALT_EN] && !wr_commit |=> !o_all_halt)
        else $error("all-module halt active while disabled");

    chk_stop_readback: assert property (
        o_wb_ack && !i_wb_we && hit(idx, `CMSC_IDX_STOP)
            |-> o_wb_dat[15:0] == state_reg.stop)
        else $error("stop register read back wrong");

    // two checks per main stop bit: set bit keeps the clock off, clear bit lets it run
    for (genvar g = 0; g < `CMSC_MAIN_PERIPH; g++) begin : g_chk
        chk_bit_halts: assert property (
            state_reg.stop[g] && !wr_commit |=> !o_periph_run[g])
            else $error("stopped module still clocked");
        chk_bit_runs: assert property (
            !state_reg.stop[g] && !wr_commit
                && !(state_reg.stop[`CMSC_BIT_ALL_MODULE_CLOCK_HALT_EN] && i_sleep_req)
                |=> o_periph_run[g])
            else $error("released module gets no clock");
    end

    chk_twowire_halt: assert property (
        !wr_commit |=>
            o_periph_run[`CMSC_MAIN_PERIPH] ==
                (!$past(state_reg.exstop[0]) && !o_all_halt)
            && o_periph_run[`CMSC_MAIN_PERIPH+1] ==
                (!$past(state_reg.exstop[1]) && !o_all_halt))
        else $error("two-wire gate does not follow its stop bit");

    chk_restore_next: assert property (
        wr_commit && hit(idx, `CMSC_IDX_STOP) && i_wb_sel[0]
            && !i_wb_dat[0] && !i_sleep_req
            |=> o_periph_run[0] ##1 o_periph_run[0] || wr_commit
                || i_sleep_req || $past(i_sleep_req))
        else $error("clock not restored the cycle after clearing");

    // leaving reset, every module runs at the default factors
    chk_reset_state: assert property (
        $rose(i_reset_n) |-> o_periph_run == '1 && !o_all_halt
            && !o_wb_ack && o_clk_cfg.sys_div_sel == RST_DIV
            && o_clk_cfg.pll_mult == RST_PLL)
        else $error("state after reset is not the reset state");

    // no answer without a request on the bus
    chk_ack_needs_req: assert property (
        !req |=> !o_wb_ack)
        else $error("ack given without a request");

    // clock fields only move on a committed write
    chk_cfg_hold: assert property (
        !wr_commit |=> $stable(o_clk_cfg))
        else $error("clock configuration changed without a write");

    chk_sysctl_write: assert property (
        wr_commit && hit(idx, `CMSC_IDX_SYSCTL) && i_wb_sel[0]
            |=> o_sysctl == $past(i_wb_dat[7:0]))
        else $error("system control write did not land");

    chk_stop_write: assert property (
        wr_commit && hit(idx, `CMSC_IDX_STOP) && i_wb_sel[1:0] == 2'h3
            |=> state_reg.stop == $past(i_wb_dat[15:0]))
        else $error("stop register write did not land");

    chk_div_readback: assert property (
        o_wb_ack && !i_wb_we && hit(idx, `CMSC_IDX_SCLK)
            |-> o_wb_dat == 32'(o_clk_cfg.sys_div_sel))
        else $error("clock select read back wrong");

    chk_pll_readback: assert property (
        o_wb_ack && !i_wb_we && hit(idx, `CMSC_IDX_PLL)
            |-> o_wb_dat == 32'(o_clk_cfg.pll_mult))
        else $error("pll field read back wrong");

    chk_exstop_readback: assert property (
        o_wb_ack && !i_wb_we && hit(idx, `CMSC_IDX_EXSTOP)
            |-> o_wb_dat[`CMSC_BIT_TW1:`CMSC_BIT_TW0] == state_reg.exstop)
        else $error("extended stop register read back wrong");

endmodule : cmsc_top

// [src/cmsc_cfg.svh]
// constants for the clock and module stop controller
// assumes inclusion by the package, the controller and the bench
`ifndef CMSC_CFG_SVH
`define CMSC_CFG_SVH
// register indices; byte address is four times the index
`define CMSC_IDX_W 24
`define CMSC_IDX_SCLK 24'hff_ff3b
`define CMSC_IDX_SYSCTL 24'hff_ff3d
`define CMSC_IDX_EXSTOP 24'hff_ff43
`define CMSC_IDX_PLL 24'hff_ff45
`define CMSC_IDX_STOP 24'hff_ff47
// field values and reset values
`define CMSC_DIV_ONE 3'h0
`define CMSC_PLL_ONE 2'h0
`define CMSC_RST_SYSCTL 8'h00
`define CMSC_RST_STOP 16'h0000
`define CMSC_RST_EXSTOP 2'h0
// bit positions
`define CMSC_BIT_ALL_MODULE_CLOCK_HALT_EN 15
`define CMSC_BIT_TW1 4
`define CMSC_BIT_TW0 3
`define CMSC_MAIN_PERIPH 15
`define CMSC_NUM_PERIPH 17
`endif

// [src/cmsc_pkg.sv]
// types shared by the clock and module stop controller
// assumes cmsc_cfg.svh is on the include path
`include "cmsc_cfg.svh"
package cmsc_pkg;
    // bus handshake state, gray along idle to ack
    typedef enum logic {
        CMSC_BUS_IDLE = 1'b0,
        CMSC_BUS_ACK = 1'b1
    } cmsc_bus_st_t;

    // clock configuration handed to the clock generator
    typedef struct packed {
        logic [2:0] sys_div_sel;
        logic [1:0] pll_mult;
    } cmsc_clk_cfg_t;

    // whole state of the controller
    typedef struct packed {
        cmsc_bus_st_t bus;
        logic ack;
        logic [31:0] rdat;
        cmsc_clk_cfg_t clk;
        logic [7:0] sysctl;
        logic [15:0] stop;
        logic [1:0] exstop;
        logic [`CMSC_NUM_PERIPH-1:0] run;
        logic all_halt;
    } cmsc_state_t;
endpackage : cmsc_pkg

// [verification/cmsc_top_tb.sv]
// self-checking bench for the clock and module stop controller
// assumes cmsc_cfg.svh on the include path and cmsc_top compiled first
`include "cmsc_cfg.svh"
module cmsc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [25:0] wb_adr = 26'h000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic sleep_req = 1'b0;
    logic ack;
    logic [31:0] rdat;
    cmsc_pkg::cmsc_clk_cfg_t clk_cfg;
    logic [7:0] sysctl;
    logic [`CMSC_NUM_PERIPH-1:0] run;
    logic all_halt;
    logic [31:0] rd;
    logic [16:0] e;
    int bad_count = 0;
    int checks_done = 0;

    // 25 MHz reference
    always #20 i_ref_clk = ~i_ref_clk;

    cmsc_top dut (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_wb_cyc(wb_cyc),
        .i_wb_stb(wb_stb),
        .i_wb_we(wb_we),
        .i_wb_adr(wb_adr),
        .i_wb_sel(wb_sel),
        .i_wb_dat(wb_dat),
        .i_sleep_req(sleep_req),
        .o_wb_ack(ack),
        .o_wb_dat(rdat),
        .o_clk_cfg(clk_cfg),
        .o_sysctl(sysctl),
        .o_periph_run(run),
        .o_all_halt(all_halt)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // classic cycle; ack is sampled at the rising edge, before that
    // edge's own register update lands
    task automatic wbx(input logic we, input logic [23:0] idx,
                       input logic [31:0] wdat, output logic [31:0] rdata);
        int n;
        @(posedge i_ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'h0};
        wb_sel <= 4'h3;
        wb_dat <= wdat;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            bad_count++;
            $display("FAIL wb_ack expected 1 seen 0");
            summarize();
        end
        // read data and release at the edge that takes the answer
        rdata = rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wbx

    // sleep or stop change, then one edge of lag
    task automatic lag();
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask : lag

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(negedge i_ref_clk);
        chk("run", 32'(run), 32'h0001_ffff);
        chk("all_halt", 32'(all_halt), 32'h0000_0000);
        wbx(1'b0, `CMSC_IDX_SCLK, 32'h0000_0000, rd);
        chk("div_rd", rd, 32'h0000_0000);
        wbx(1'b0, `CMSC_IDX_PLL, 32'h0000_0000, rd);
        chk("pll_rd", rd, 32'h0000_0000);
        $display("test reset done");
        // nonzero first, so a stuck field cannot pass for 000
        wbx(1'b1, `CMSC_IDX_SCLK, 32'h0000_0005, rd);
        @(negedge i_ref_clk);
        chk("div", 32'(clk_cfg.sys_div_sel), 32'h0000_0005);
        wbx(1'b1, `CMSC_IDX_SCLK, 32'h0000_0000, rd);
        @(negedge i_ref_clk);
        chk("div", 32'(clk_cfg.sys_div_sel), 32'h0000_0000);
        wbx(1'b1, `CMSC_IDX_PLL, 32'h0000_0003, rd);
        @(negedge i_ref_clk);
        chk("pll", 32'(clk_cfg.pll_mult), 32'h0000_0003);
        wbx(1'b1, `CMSC_IDX_PLL, 32'h0000_0000, rd);
        @(negedge i_ref_clk);
        chk("pll", 32'(clk_cfg.pll_mult), 32'h0000_0000);
        // system control: reset value, write, read back
        chk("sysctl", 32'(sysctl), 32'h0000_0000);
        wbx(1'b1, `CMSC_IDX_SYSCTL, 32'h0000_00a5, rd);
        @(negedge i_ref_clk);
        chk("sysctl", 32'(sysctl), 32'h0000_00a5);
        wbx(1'b0, `CMSC_IDX_SYSCTL, 32'h0000_0000, rd);
        chk("sysctl_rd", rd, 32'h0000_00a5);
        $display("test clock config done");
        // walk one stop bit across bits 0 to 14 of the main register
        for (int i = 0; i < 15; i++) begin
            wbx(1'b1, `CMSC_IDX_STOP, 32'h1 << i, rd);
            @(negedge i_ref_clk);
            e = 17'h1_ffff & ~(17'h0_0001 << i);
            chk("run", 32'(run), 32'(e));
            wbx(1'b0, `CMSC_IDX_STOP, 32'h0000_0000, rd);
            chk("stop_rd", rd, 32'h1 << i);
        end
        wbx(1'b1, `CMSC_IDX_STOP, 32'h0000_0000, rd);
        @(negedge i_ref_clk);
        chk("run", 32'(run), 32'h0001_ffff);
        $display("test stop walk done");
        wbx(1'b1, `CMSC_IDX_EXSTOP, 32'h0000_0010, rd);
        @(negedge i_ref_clk);
        chk("run", 32'(run), 32'h0000_ffff);
        wbx(1'b1, `CMSC_IDX_EXSTOP, 32'h0000_0008, rd);
        @(negedge i_ref_clk);
        chk("run", 32'(run), 32'h0001_7fff);
        wbx(1'b0, `CMSC_IDX_EXSTOP, 32'h0000_0000, rd);
        chk("exstop_rd", rd, 32'h0000_0008);
        wbx(1'b1, `CMSC_IDX_EXSTOP, 32'h0000_0000, rd);
        $display("test extended stop done");
        // sleep without the enable bit must not halt anything
        @(posedge i_ref_clk);
        sleep_req <= 1'b1;
        lag();
        chk("all_halt", 32'(all_halt), 32'h0000_0000);
        wbx(1'b1, `CMSC_IDX_STOP, 32'h0000_8000, rd);
        lag();
        chk("all_halt", 32'(all_halt), 32'h0000_0001);
        chk("run", 32'(run), 32'h0000_0000);
        @(posedge i_ref_clk);
        sleep_req <= 1'b0;
        lag();
        chk("all_halt", 32'(all_halt), 32'h0000_0000);
        chk("run", 32'(run), 32'h0001_ffff);
        wbx(1'b1, `CMSC_IDX_STOP, 32'h0000_0000, rd);
        $display("test all halt done");
        // unmapped place: write ignored, reads zero
        wbx(1'b1, 24'h00_0010, 32'hffff_ffff, rd);
        wbx(1'b0, 24'h00_0010, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
        chk("run", 32'(run), 32'h0001_ffff);
        $display("test unmapped done");
        summarize();
    end
endmodule : cmsc_top_tb
